// ==== hw/annp_pkg.sv ====
package annp_pkg;
    // ---------------------------------------------------------------
    // register byte addresses
    // ---------------------------------------------------------------
    localparam logic [7:0]  EXPANSION_STATUS_ADDR = 8'h98;
    localparam logic [7:0]  NEXT_PAGE_TX_ADDR     = 8'h9c;
    localparam logic [7:0]  PHY_SUMMARY_ADDR      = 8'hc0;
    localparam logic [7:0]  IRQ_STATUS_ADDR       = 8'he0;
    localparam logic [7:0]  IRQ_MASK_ADDR         = 8'he4;
    localparam logic [7:0]  PAGE_SENT_ADDR        = 8'he8;

    // ---------------------------------------------------------------
    // expansion status fields
    // ---------------------------------------------------------------
    localparam int EXP_FAULT_BIT        = 4;
    localparam int EXP_PARTNER_NEXT_BIT = 3;
    localparam int EXP_LOCAL_NEXT_BIT   = 2;
    localparam int EXP_PAGE_RX_BIT      = 1;
    localparam int EXP_LP_AN_BIT        = 0;

    // ---------------------------------------------------------------
    // next page transmit fields
    // ---------------------------------------------------------------
    localparam int NPT_REQ_BIT    = 15;
    localparam int NPT_MSG_BIT    = 13;
    localparam int NPT_COMPLY_BIT = 12;
    localparam int NPT_TOG_BIT    = 11;
    localparam int NPT_CODE_MSB   = 10;
    localparam logic [15:0] NPT_RESET     = 16'h2001;
    localparam logic [15:0] NPT_WR_MASK   = 16'hb7ff;
    localparam logic [10:0] NULL_PAGE     = 11'h001;

    // ---------------------------------------------------------------
    // phy summary and interrupt fields
    // ---------------------------------------------------------------
    localparam int SUM_PAGE_RX_BIT = 8;
    localparam int IRQ_PAGE_RX_BIT = 0;
    localparam int IRQ_FAULT_BIT   = 1;
    localparam logic [1:0] AXI_OKAY   = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage

// ==== hw/annp_regs.sv ====
// Functional notes
// - Expansion status bits 15:5 ignore writes and read zero.
// - Bit 4 shows a parallel detection fault and is zero otherwise.
// - Bit 3 shows whether the partner supports next page exchange.
// - Bit 2 reads one since the local device can send more next pages.
// - Bit 1 latches page reception, is read-only, and clears when the register is read.
// - Bit 0 shows whether the partner supports auto-negotiation.
// - The next page transmit register at 0x9c resets to 0x2001 and is the page sent to the partner.
// - Transmit bit 15 requests another page and resets to zero; bit 14 reads zero and ignores writes.
// - Transmit bit 13 marks a message page, resets to one.
// - Transmit bit 12 says the device will comply, resets to zero, software owned.
// - Transmit bit 11 is read-only, resets to zero and is the inverse of the last sent toggle.
// - Each sent page carries the toggle opposite to the previous exchanged page.
// - Transmit bits 10:0 hold the message code or unformatted payload.
// - The payload resets to the null page value 1.
// - Summary status bit 8 duplicates page received and is not cleared by reading the summary.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module annp_regs
    import annp_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        pd_fault,
    input  wire logic        partner_next_page_capable,
    input  wire logic        partner_autoneg_capable,
    input  wire logic        page_rx_pulse,
    input  wire logic        page_sent_pulse,
    output var  logic [15:0] next_page_word,
    output var  logic        irq
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        aw_held;
        logic        w_held;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [15:0] npt;
        logic        tx_tog;
        logic        page_rx;
        logic [1:0]  irq_status;
        logic [1:0]  irq_mask;
        logic [15:0] pages_sent;
        logic [2:0]  sync_a;
        logic [2:0]  sync_b;
        logic        sent_d;
        logic        rx_d;
        logic        irq;
    } annp_state_type;

    annp_state_type r;
    annp_state_type next_r;

    logic        wr_go;
    logic        rd_go;
    logic [15:0] exp_view;
    logic [15:0] sum_view;

    // ---------------------------------------------------------------
    // combinational views
    // ---------------------------------------------------------------
    // sync_b holds second-stage values: {fault, partner next page, partner autoneg}
    always_comb begin
        exp_view = 16'h0000;
        exp_view[EXP_FAULT_BIT]        = r.sync_b[2];
        exp_view[EXP_PARTNER_NEXT_BIT] = r.sync_b[1];
        exp_view[EXP_LOCAL_NEXT_BIT]   = 1'b1;
        exp_view[EXP_PAGE_RX_BIT] = r.page_rx;
        exp_view[EXP_LP_AN_BIT]   = r.sync_b[0];
        sum_view = 16'h0000;
        sum_view[SUM_PAGE_RX_BIT] = r.page_rx;
    end

    // a write fires once both halves are held and the last response is gone
    assign wr_go   = r.aw_held & r.w_held & ~r.bvalid;
    assign rd_go   = s_axi_arvalid & r.arready;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        logic page_ev;
        logic tx_ev;
        logic [15:0] wmask;
        page_ev = 1'b0;
        tx_ev   = 1'b0;
        wmask   = 16'h0000;
        next_r  = r;
        // two-flop synchronisers; stage a is read only by stage b
        next_r.sync_a = {pd_fault, partner_next_page_capable, partner_autoneg_capable};
        next_r.sync_b = r.sync_a;
        next_r.rx_d   = page_rx_pulse;
        next_r.sent_d = page_sent_pulse;
        page_ev = r.rx_d;
        tx_ev   = r.sent_d;

        // write address and data taken in either order
        if (s_axi_awvalid && r.awready) begin
            next_r.aw_held = 1'b1;
            next_r.awaddr  = s_axi_awaddr;
            next_r.awready = 1'b0;
        end
        if (s_axi_wvalid && r.wready) begin
            next_r.w_held = 1'b1;
            next_r.wdata  = s_axi_wdata;
            next_r.wstrb  = s_axi_wstrb;
            next_r.wready = 1'b0;
        end
        wmask = {{8{r.wstrb[1]}}, {8{r.wstrb[0]}}};
        if (wr_go) begin
            next_r.bvalid  = 1'b1;
            next_r.bresp   = AXI_OKAY;
            next_r.aw_held = 1'b0;
            next_r.w_held  = 1'b0;
            case (r.awaddr)
                NEXT_PAGE_TX_ADDR: begin
                    // toggle mirror and bit 14 stay out of the write mask
                    wmask = wmask & NPT_WR_MASK;
                    next_r.npt = (r.npt & ~wmask) | (r.wdata[15:0] & wmask);
                end
                IRQ_STATUS_ADDR: next_r.irq_status = r.irq_status & ~(r.wdata[1:0] & {2{r.wstrb[0]}});
                IRQ_MASK_ADDR:   if (r.wstrb[0]) next_r.irq_mask = r.wdata[1:0];
                EXPANSION_STATUS_ADDR, PHY_SUMMARY_ADDR, PAGE_SENT_ADDR: ;
                default: next_r.bresp = AXI_SLVERR;
            endcase
        end
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid  = 1'b0;
            next_r.awready = 1'b1;
            next_r.wready  = 1'b1;
        end

        // read channel; one read outstanding
        if (rd_go) begin
            next_r.arready = 1'b0;
            next_r.rvalid  = 1'b1;
            next_r.rresp   = AXI_OKAY;
            next_r.rdata   = 32'h0000_0000;
            case (s_axi_araddr)
                EXPANSION_STATUS_ADDR: begin
                    next_r.rdata[15:0] = exp_view;
                    next_r.page_rx     = 1'b0;
                end
                NEXT_PAGE_TX_ADDR: next_r.rdata[15:0] = r.npt;
                PHY_SUMMARY_ADDR:  next_r.rdata[15:0] = sum_view;
                IRQ_STATUS_ADDR:   next_r.rdata[1:0]  = r.irq_status;
                IRQ_MASK_ADDR:     next_r.rdata[1:0]  = r.irq_mask;
                PAGE_SENT_ADDR:    next_r.rdata[15:0] = r.pages_sent;
                default:           next_r.rresp       = AXI_SLVERR;
            endcase
        end
        if (r.rvalid && s_axi_rready) begin
            next_r.rvalid  = 1'b0;
            next_r.arready = 1'b1;
        end

        // page received: set wins over the clear-on-read above
        if (page_ev) begin
            next_r.page_rx = 1'b1;
            next_r.irq_status[IRQ_PAGE_RX_BIT] = 1'b1;
        end
        if (r.sync_b[2]) begin
            next_r.irq_status[IRQ_FAULT_BIT] = 1'b1;
        end
        // a sent page flips the toggle; mirror holds the inverse of the last sent toggle
        if (tx_ev) begin
            next_r.tx_tog = ~r.tx_tog;
            next_r.npt[NPT_TOG_BIT] = ~r.tx_tog;
            next_r.pages_sent = r.pages_sent + 16'h0001;
        end
        next_r.irq = |(next_r.irq_status & r.irq_mask);
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            r            <= '0;
            r.awready    <= 1'b1;
            r.wready     <= 1'b1;
            r.arready    <= 1'b1;
            r.npt        <= NPT_RESET;
        end else begin
            r <= next_r;
        end
    end

    // transmitted word: the toggle has its own flop so the output needs no gate
    assign next_page_word = {r.npt[15:12], r.tx_tog, r.npt[NPT_CODE_MSB:0]};
    assign s_axi_awready  = r.awready;
    assign s_axi_wready   = r.wready;
    assign s_axi_bvalid   = r.bvalid;
    assign s_axi_bresp    = r.bresp;
    assign s_axi_arready  = r.arready;
    assign s_axi_rvalid   = r.rvalid;
    assign s_axi_rdata    = r.rdata;
    assign s_axi_rresp    = r.rresp;
    assign irq            = r.irq;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    property p_reserved_zero;
        @(posedge core_clk) disable iff (!rst_n)
        (rd_go && s_axi_araddr == EXPANSION_STATUS_ADDR) |=> s_axi_rdata[31:5] == 27'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

    property p_fault_flag;
        @(posedge core_clk) disable iff (!rst_n)
        (rd_go && s_axi_araddr == EXPANSION_STATUS_ADDR) |=> s_axi_rdata[EXP_FAULT_BIT] == $past(r.sync_b[2]);
    endproperty
    a_fault_flag: assert property (p_fault_flag) else $error("fault flag mismatch");

    property p_partner_next;
        @(posedge core_clk) disable iff (!rst_n)
        (rd_go && s_axi_araddr == EXPANSION_STATUS_ADDR) |=>
            s_axi_rdata[EXP_PARTNER_NEXT_BIT] == $past(r.sync_b[1]);
    endproperty
    a_partner_next: assert property (p_partner_next) else $error("partner next page flag mismatch");

    property p_local_next;
        @(posedge core_clk) disable iff (!rst_n)
        (rd_go && s_axi_araddr == EXPANSION_STATUS_ADDR) |=> s_axi_rdata[EXP_LOCAL_NEXT_BIT];
    endproperty
    a_local_next: assert property (p_local_next) else $error("local next page flag low");

    property p_cor;
        @(posedge core_clk) disable iff (!rst_n)
        (rd_go && s_axi_araddr == EXPANSION_STATUS_ADDR && !r.rx_d) |=> !r.page_rx;
    endproperty
    a_cor: assert property (p_cor) else $error("page flag not cleared on read");

    property p_lp_an;
        @(posedge core_clk) disable iff (!rst_n)
        (rd_go && s_axi_araddr == EXPANSION_STATUS_ADDR) |=> s_axi_rdata[EXP_LP_AN_BIT] == $past(r.sync_b[0]);
    endproperty
    a_lp_an: assert property (p_lp_an) else $error("partner autoneg flag mismatch");

    property p_rsv14;
        @(posedge core_clk) disable iff (!rst_n)
        r.npt[14] == 1'b0;
    endproperty
    a_rsv14: assert property (p_rsv14) else $error("bit 14 set");

    property p_toggle;
        @(posedge core_clk) disable iff (!rst_n)
        r.sent_d |=> next_page_word[NPT_TOG_BIT] != $past(next_page_word[NPT_TOG_BIT]);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle did not flip");

    property p_mirror;
        @(posedge core_clk) disable iff (!rst_n)
        (wr_go && r.awaddr == NEXT_PAGE_TX_ADDR && !r.sent_d) |=> $stable(r.npt[NPT_TOG_BIT]);
    endproperty
    a_mirror: assert property (p_mirror) else $error("write changed toggle mirror");

    property p_summary;
        @(posedge core_clk) disable iff (!rst_n)
        (rd_go && s_axi_araddr == PHY_SUMMARY_ADDR && r.page_rx) |=> r.page_rx;
    endproperty
    a_summary: assert property (p_summary) else $error("summary read cleared flag");

    // ---------------------------------------------------------------
    // event, transmit and handshake assertions
    // ---------------------------------------------------------------
    // a fault level latches its interrupt bit even against a clear
    property p_fault_irq;
        @(posedge core_clk) disable iff (!rst_n)
        r.sync_b[2] |=> r.irq_status[IRQ_FAULT_BIT];
    endproperty
    a_fault_irq: assert property (p_fault_irq) else $error("fault did not latch");

    // a received page sets the flag even in the cycle of a status read
    property p_page_set;
        @(posedge core_clk) disable iff (!rst_n)
        r.rx_d |=> r.page_rx && r.irq_status[IRQ_PAGE_RX_BIT];
    endproperty
    a_page_set: assert property (p_page_set) else $error("page flag not set");

    // the summary copy shows the flag as it stood when the read was taken
    property p_summary_dup;
        @(posedge core_clk) disable iff (!rst_n)
        (rd_go && s_axi_araddr == PHY_SUMMARY_ADDR) |=> s_axi_rdata[SUM_PAGE_RX_BIT] == $past(r.page_rx);
    endproperty
    a_summary_dup: assert property (p_summary_dup) else $error("summary copy mismatch");

    // transmit read: upper half and the reserved bit stay zero
    property p_npt_read;
        @(posedge core_clk) disable iff (!rst_n)
        (rd_go && s_axi_araddr == NEXT_PAGE_TX_ADDR) |=> s_axi_rdata[31:16] == 16'h0000 && !s_axi_rdata[14];
    endproperty
    a_npt_read: assert property (p_npt_read) else $error("transmit read has stray bits");

    // a full write lands the request, message and comply bits
    property p_npt_write;
        @(posedge core_clk) disable iff (!rst_n)
        (wr_go && r.awaddr == NEXT_PAGE_TX_ADDR && r.wstrb[1:0] == 2'b11) |=>
            r.npt[NPT_REQ_BIT] == $past(r.wdata[NPT_REQ_BIT]) && r.npt[NPT_MSG_BIT] == $past(r.wdata[NPT_MSG_BIT])
            && r.npt[NPT_COMPLY_BIT] == $past(r.wdata[NPT_COMPLY_BIT]);
    endproperty
    a_npt_write: assert property (p_npt_write) else $error("transmit flag write lost");

    // a full write lands the payload unchanged
    property p_code_write;
        @(posedge core_clk) disable iff (!rst_n)
        (wr_go && r.awaddr == NEXT_PAGE_TX_ADDR && r.wstrb[1:0] == 2'b11) |=>
            r.npt[NPT_CODE_MSB:0] == $past(r.wdata[NPT_CODE_MSB:0]);
    endproperty
    a_code_write: assert property (p_code_write) else $error("payload write lost");

    // after a sent page the mirror reads the inverse of the toggle just sent
    property p_mirror_inv;
        @(posedge core_clk) disable iff (!rst_n)
        r.sent_d |=> r.npt[NPT_TOG_BIT] == !$past(next_page_word[NPT_TOG_BIT]);
    endproperty
    a_mirror_inv: assert property (p_mirror_inv) else $error("mirror not inverse of sent toggle");

    // every sent page steps the counter by one
    property p_sent_count;
        @(posedge core_clk) disable iff (!rst_n)
        r.sent_d |=> r.pages_sent == $past(r.pages_sent) + 16'h0001;
    endproperty
    a_sent_count: assert property (p_sent_count) else $error("sent count did not step");

    // the output rises only for a status bit whose mask bit was set
    property p_irq_masked;
        @(posedge core_clk) disable iff (!rst_n)
        irq |-> (r.irq_status & $past(r.irq_mask)) != 2'b00;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("interrupt without enabled source");

    // a write answers one cycle after both halves are held
    property p_b_answer;
        @(posedge core_clk) disable iff (!rst_n)
        (r.aw_held && r.w_held) |=> s_axi_bvalid;
    endproperty
    a_b_answer: assert property (p_b_answer) else $error("write response late");

    // no new write is taken while a response is pending
    property p_w_refuse;
        @(posedge core_clk) disable iff (!rst_n)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_w_refuse: assert property (p_w_refuse) else $error("write taken during response");

    // no new read is taken while read data is pending
    property p_ar_refuse;
        @(posedge core_clk) disable iff (!rst_n)
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_refuse: assert property (p_ar_refuse) else $error("read taken during response");
endmodule
`default_nettype wire

// ==== testbench/annp_partner.sv ====
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// link partner stand-in: abilities, received and accepted pages
// ---------------------------------------------------------------
module annp_partner (
    input  wire logic        core_clk,
    input  wire logic [15:0] next_page_word,
    output var  logic        pd_fault,
    output var  logic        partner_next_page_capable,
    output var  logic        partner_autoneg_capable,
    output var  logic        page_rx_pulse,
    output var  logic        page_sent_pulse
);
    logic [15:0] last_word = 16'h0000;

    // quiet partner at time zero
    initial begin
        pd_fault = 1'b0;
        partner_next_page_capable = 1'b0;
        partner_autoneg_capable = 1'b0;
        page_rx_pulse = 1'b0;
        page_sent_pulse = 1'b0;
    end

    // levels only; the block synchronises them, so allow a few cycles
    task automatic set_levels(input logic pd, input logic np, input logic an);
        pd_fault <= pd;
        partner_next_page_capable <= np;
        partner_autoneg_capable <= an;
    endtask

    // one link code word arrives as a single-cycle strobe
    task automatic recv_page();
        page_rx_pulse <= 1'b1;
        @(posedge core_clk);
        page_rx_pulse <= 1'b0;
    endtask

    // partner takes our page; the word is kept as it stood on the wire
    task automatic take_page();
        page_sent_pulse <= 1'b1;
        last_word <= next_page_word;
        @(posedge core_clk);
        page_sent_pulse <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import annp_pkg::*;
;
    logic        core_clk = 1'b0, rst_n = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq, pd, npc, anc, rxp, sxp;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] npw;
    logic [15:0] npt_m = NPT_RESET;
    logic        tog_m = 1'b0;
    int          sent_m = 0, err_count = 0, check_count = 0;

    // 250 MHz core clock
    always #2 core_clk = ~core_clk;

    annp_regs annp_regs_inst (.core_clk(core_clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pd_fault(pd), .partner_next_page_capable(npc), .partner_autoneg_capable(anc),
        .page_rx_pulse(rxp), .page_sent_pulse(sxp), .next_page_word(npw), .irq(irq));

    annp_partner annp_partner_inst (.core_clk(core_clk), .next_page_word(npw), .pd_fault(pd),
        .partner_next_page_capable(npc), .partner_autoneg_capable(anc),
        .page_rx_pulse(rxp), .page_sent_pulse(sxp));

    // ---------------------------------------------------------------
    // comparison, bus tasks and closing
    // ---------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // extra edge at the end keeps a follow-on call from assigning ready twice
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = AXI_OKAY);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && n < 64);
        check("bvalid", {31'h0, bvalid}, 32'h1);
        if (!$isunknown(er)) check("bresp", {30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e,
                       input logic [31:0] m = 32'hffffffff, input logic [1:0] er = AXI_OKAY);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && n < 64);
        check("rvalid", {31'h0, rvalid}, 32'h1);
        check(nm, rdata & m, e);
        check("rresp", {30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
        @(posedge core_clk);
    endtask

    // model view of the transmit register: mirror bit comes from the toggle
    function automatic logic [31:0] npt_exp();
        return {16'h0, (npt_m & NPT_WR_MASK) | {4'h0, tog_m, 11'h0}};
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // watchdog: the whole run needs well under a few thousand cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        results();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        logic [31:0] d;
        void'($urandom(32'h630981fa));
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rdc("exp_status", EXPANSION_STATUS_ADDR, 32'h0004);
        rdc("npt", NEXT_PAGE_TX_ADDR, 32'h2001);
        check("word", {16'h0, npw}, 32'h2001);
        $display("test reset done");
        // every ability combination; writes to the status word must not stick
        for (int i = 0; i < 8; i++) begin
            annp_partner_inst.set_levels(i[2], i[1], i[0]);
            repeat (4) @(posedge core_clk);
            wr(EXPANSION_STATUS_ADDR, 32'hffff);
            rdc("exp_status", EXPANSION_STATUS_ADDR, {27'h0, i[2], i[1], 1'b1, 1'b0, i[0]});
        end
        annp_partner_inst.set_levels(1'b0, 1'b1, 1'b1);
        $display("test abilities done");
        annp_partner_inst.recv_page();
        repeat (4) @(posedge core_clk);
        rdc("summary", PHY_SUMMARY_ADDR, 32'h100, 32'h100);
        rdc("summary", PHY_SUMMARY_ADDR, 32'h100, 32'h100);
        rdc("exp_status", EXPANSION_STATUS_ADDR, 32'h000f);
        rdc("exp_status", EXPANSION_STATUS_ADDR, 32'h000d);
        rdc("summary", PHY_SUMMARY_ADDR, 32'h0, 32'h100);
        $display("test page received done");
        // interrupt: a set mask bit lets its source through; raise, mask, second source, clear
        wr(IRQ_STATUS_ADDR, 32'h3);
        wr(IRQ_MASK_ADDR, 32'h1);
        repeat (3) @(posedge core_clk);
        check("irq", {31'h0, irq}, 32'h0);
        annp_partner_inst.recv_page();
        repeat (4) @(posedge core_clk);
        check("irq", {31'h0, irq}, 32'h1);
        rdc("irq_status", IRQ_STATUS_ADDR, 32'h1, 32'h3);
        wr(IRQ_MASK_ADDR, 32'h2);
        rdc("irq_mask", IRQ_MASK_ADDR, 32'h2, 32'h3);
        check("irq", {31'h0, irq}, 32'h0);
        annp_partner_inst.set_levels(1'b1, 1'b1, 1'b1);
        repeat (6) @(posedge core_clk);
        annp_partner_inst.set_levels(1'b0, 1'b1, 1'b1);
        repeat (4) @(posedge core_clk);
        check("irq", {31'h0, irq}, 32'h1);
        rdc("irq_status", IRQ_STATUS_ADDR, 32'h3, 32'h3);
        wr(IRQ_STATUS_ADDR, 32'h3);
        rdc("irq_status", IRQ_STATUS_ADDR, 32'h0, 32'h3);
        check("irq", {31'h0, irq}, 32'h0);
        $display("test interrupt done");
        // transmit word: all ones, all zeros, then random payloads
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 32'hffff : (i == 1) ? 32'h0 : $urandom;
            wr(NEXT_PAGE_TX_ADDR, d);
            npt_m = d[15:0];
            rdc("npt", NEXT_PAGE_TX_ADDR, npt_exp());
            check("word", {16'h0, npw}, npt_exp());
            annp_partner_inst.take_page();
            repeat (2) @(posedge core_clk);
            check("sent_tog", {31'h0, annp_partner_inst.last_word[11]}, {31'h0, tog_m});
            tog_m = ~tog_m;
            sent_m++;
            rdc("npt", NEXT_PAGE_TX_ADDR, npt_exp());
            check("word", {16'h0, npw}, npt_exp());
            rdc("sent_count", PAGE_SENT_ADDR, 32'(sent_m), 32'hff);
        end
        $display("test transmit done");
        // reset in mid-run: toggle state, transmit word and count fall back
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        npt_m = NPT_RESET;
        tog_m = 1'b0;
        rdc("npt", NEXT_PAGE_TX_ADDR, npt_exp());
        check("word", {16'h0, npw}, 32'h2001);
        rdc("sent_count", PAGE_SENT_ADDR, 32'h0, 32'hff);
        $display("test reset again done");
        wr(8'h10, 32'h1, AXI_SLVERR);
        rdc("unmapped", 8'h10, 32'h0, 32'h0, AXI_SLVERR);
        $display("test unmapped done");
        results();
    end
endmodule
`default_nettype wire
